// File: eac_controller.sv
// Access controller for the byte-wide data nonvolatile memory
`timescale 1ns/1ps

module eac_controller #(
    parameter int NV_BYTES           = 512,
    parameter int ERASE_WRITE_CYCLES = eac_pkg::ERASE_WRITE_CYCLES,
    parameter int SINGLE_CYCLES      = eac_pkg::SINGLE_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic [5:0] io_addr_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_wdata_in,
    input  wire logic       global_irq_enable_in,
    output logic [7:0]      io_rdata_out,
    output logic            cpu_stall_out,
    output logic            nv_ready_irq_out,
    output logic            nv_busy_out
);
    localparam int ADDR_W = 9;
    localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'(NV_BYTES - 1);
    localparam int CW = eac_pkg::PROG_CNT_W;

    eac_nv_if #(.ADDR_W(ADDR_W)) nv ();

    eac_nv_array #(.DEPTH(NV_BYTES), .ADDR_W(ADDR_W)) u_array (
        .clk_in (clk_in),
        .nv     (nv.mem)
    );

    function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] off);
        reg_hit = (a == off);
    endfunction

    logic [ADDR_W-1:0] nv_address_q, nv_address_d;
    logic [7:0]        nv_data_byte_q, nv_data_byte_d;
    logic [1:0]        prog_mode_field_q, prog_mode_field_d;
    logic              ready_irq_enable_q, ready_irq_enable_d;
    logic              master_prog_arm_q, master_prog_arm_d;
    logic [2:0]        arm_cnt_q, arm_cnt_d;
    logic              prog_en_q, prog_en_d;
    logic [CW-1:0]     prog_cnt_q, prog_cnt_d;
    logic [ADDR_W-1:0] op_addr_q, op_addr_d;
    logic [7:0]        op_data_q, op_data_d;
    logic [2:0]        stall_cnt_q, stall_cnt_d;
    logic              rd_pend_q, rd_pend_d;
    logic [7:0]        io_rdata_q, io_rdata_d;

    logic ctl_wr, arm_wr, start_req, start_ok, read_ok, prog_done;

    always_comb begin
        ctl_wr    = io_wr_in && reg_hit(io_addr_in, eac_pkg::OFF_CONTROL);
        arm_wr    = ctl_wr && io_wdata_in[eac_pkg::CTL_MASTER_ARM];
        start_req = ctl_wr && io_wdata_in[eac_pkg::CTL_PROG_EN];
        // Only a held reserved mode is refused; a start write that itself selects reserved mode still starts
        start_ok  = start_req && master_prog_arm_q && !prog_en_q
                    && prog_mode_field_q != eac_pkg::MODE_RESERVED;
        read_ok   = ctl_wr && io_wdata_in[eac_pkg::CTL_READ_STROBE] && !prog_en_q;
        prog_done = prog_en_q && prog_cnt_q == CW'(1);

        nv_address_d       = nv_address_q;
        nv_data_byte_d     = nv_data_byte_q;
        prog_mode_field_d  = prog_mode_field_q;
        ready_irq_enable_d = ready_irq_enable_q;
        master_prog_arm_d  = master_prog_arm_q;
        arm_cnt_d          = arm_cnt_q;
        prog_en_d          = prog_en_q;
        prog_cnt_d         = prog_cnt_q;
        op_addr_d          = op_addr_q;
        op_data_d          = op_data_q;
        stall_cnt_d        = (stall_cnt_q != 3'h0) ? stall_cnt_q - 3'h1 : 3'h0;
        rd_pend_d          = read_ok;
        io_rdata_d         = io_rdata_q;

        // Address writes frozen during programming
        if (io_wr_in && !prog_en_q) begin
            if (reg_hit(io_addr_in, eac_pkg::OFF_ADDR_LOW)) begin
                nv_address_d[7:0] = io_wdata_in & ADDR_MASK[7:0];
            end
            if (reg_hit(io_addr_in, eac_pkg::OFF_ADDR_HIGH)) begin
                nv_address_d[8] = io_wdata_in[0] & ADDR_MASK[8];
            end
        end
        if (io_wr_in && reg_hit(io_addr_in, eac_pkg::OFF_DATA_BYTE)) begin
            nv_data_byte_d = io_wdata_in;
        end
        // Array data lands one cycle after the strobe, still inside the stall
        if (rd_pend_q) begin
            nv_data_byte_d = nv.rd_data;
        end

        if (ctl_wr) begin
            ready_irq_enable_d = io_wdata_in[eac_pkg::CTL_READY_IRQ];
            if (!prog_en_q) begin
                prog_mode_field_d = io_wdata_in[eac_pkg::CTL_MODE_HI:eac_pkg::CTL_MODE_LO];
            end
        end

        // Arm window: rewriting the arm bit restarts the window
        if (arm_wr) begin
            master_prog_arm_d = 1'b1;
            arm_cnt_d         = eac_pkg::ARM_CYCLES;
        end else if (master_prog_arm_q) begin
            arm_cnt_d = arm_cnt_q - 3'h1;
            if (arm_cnt_q == 3'h1) begin
                master_prog_arm_d = 1'b0;
            end
        end

        if (start_ok) begin
            prog_en_d   = 1'b1;
            prog_cnt_d  = (prog_mode_field_q == eac_pkg::MODE_ERASE_WRITE)
                          ? CW'(ERASE_WRITE_CYCLES) : CW'(SINGLE_CYCLES);
            op_addr_d   = nv_address_q;
            op_data_d   = nv_data_byte_q;
            stall_cnt_d = eac_pkg::PROG_STALL;
        end else if (prog_en_q) begin
            prog_cnt_d = prog_cnt_q - CW'(1);
            if (prog_done) begin
                prog_en_d = 1'b0;
            end
        end
        if (read_ok) begin
            stall_cnt_d = eac_pkg::READ_STALL;
        end

        if (io_rd_in) begin
            case (io_addr_in)
                eac_pkg::OFF_CONTROL:   io_rdata_d = {2'h0, prog_mode_field_q,
                                            ready_irq_enable_q, master_prog_arm_q,
                                            prog_en_q, 1'b0};
                eac_pkg::OFF_DATA_BYTE: io_rdata_d = nv_data_byte_q;
                eac_pkg::OFF_ADDR_LOW:  io_rdata_d = nv_address_q[7:0];
                eac_pkg::OFF_ADDR_HIGH: io_rdata_d = {7'h00, nv_address_q[8]};
                default:                io_rdata_d = 8'h00;
            endcase
        end

        if (srst_in) begin
            // A running operation survives reset, and so does its mode.
            // Clear sits in the else arm so an unknown power-up state resolves.
            if (prog_en_q) begin
                prog_en_d         = prog_en_d;
            end else begin
                prog_mode_field_d = eac_pkg::MODE_RESET;
                prog_en_d         = 1'b0;
                prog_cnt_d        = '0;
            end
            nv_data_byte_d     = eac_pkg::DATA_RESET;
            ready_irq_enable_d = 1'b0;
            master_prog_arm_d  = 1'b0;
            arm_cnt_d          = 3'h0;
            stall_cnt_d        = 3'h0;
            rd_pend_d          = 1'b0;
            io_rdata_d         = 8'h00;
        end
    end

    // Address registers carry no reset; software must load them
    always_ff @(posedge clk_in) begin
        nv_address_q       <= nv_address_d;
        nv_data_byte_q     <= nv_data_byte_d;
        prog_mode_field_q  <= prog_mode_field_d;
        ready_irq_enable_q <= ready_irq_enable_d;
        master_prog_arm_q  <= master_prog_arm_d;
        arm_cnt_q          <= arm_cnt_d;
        prog_en_q          <= prog_en_d;
        prog_cnt_q         <= prog_cnt_d;
        op_addr_q          <= op_addr_d;
        op_data_q          <= op_data_d;
        stall_cnt_q        <= stall_cnt_d;
        rd_pend_q          <= rd_pend_d;
        io_rdata_q         <= io_rdata_d;
    end

    assign nv.rd_en   = read_ok;
    assign nv.rd_addr = nv_address_q;
    assign nv.wr_en   = prog_done;
    assign nv.wr_mode = prog_mode_field_q;
    assign nv.wr_addr = op_addr_q;
    assign nv.wr_data = op_data_q;

    assign io_rdata_out     = io_rdata_q;
    assign cpu_stall_out    = stall_cnt_q != 3'h0;
    assign nv_busy_out      = prog_en_q;
    assign nv_ready_irq_out = ready_irq_enable_q && global_irq_enable_in && !prog_en_q;

    a_arm_window: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(master_prog_arm_q) |-> master_prog_arm_q [*4])
        else $error("arm bit dropped early");
    a_arm_expiry: assert property (@(posedge clk_in) disable iff (srst_in)
        (master_prog_arm_q && arm_cnt_q == 3'h1 && !arm_wr) |=> !master_prog_arm_q)
        else $error("arm bit not cleared");
    a_mode_locked: assert property (@(posedge clk_in) disable iff (srst_in)
        prog_en_q |=> prog_mode_field_q == $past(prog_mode_field_q))
        else $error("mode changed while programming");
    a_unarmed_start: assert property (@(posedge clk_in) disable iff (srst_in)
        (start_req && !master_prog_arm_q) |=> !$rose(prog_en_q))
        else $error("start without arm");
    a_prog_stall: assert property (@(posedge clk_in) disable iff (srst_in)
        ($rose(prog_en_q) && !rd_pend_q) |-> cpu_stall_out [*2] ##1 !cpu_stall_out)
        else $error("program stall length wrong");
    a_read_stall: assert property (@(posedge clk_in) disable iff (srst_in)
        read_ok |=> cpu_stall_out [*4] ##1 !cpu_stall_out)
        else $error("read stall length wrong");
    a_read_data: assert property (@(posedge clk_in) disable iff (srst_in)
        read_ok |-> ##2 nv_data_byte_q == $past(nv.rd_data))
        else $error("read byte not loaded");
    a_read_blocked: assert property (@(posedge clk_in) disable iff (srst_in)
        prog_en_q |=> (nv_address_q == $past(nv_address_q)) && !rd_pend_q)
        else $error("access while programming");
    a_prog_end: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(prog_en_q) |-> $past(prog_cnt_q) == CW'(1) && $past(nv.wr_en))
        else $error("programming ended off count");
    a_irq_level: assert property (@(posedge clk_in) disable iff (srst_in)
        nv_ready_irq_out |-> !nv_busy_out && global_irq_enable_in)
        else $error("ready request while busy");
    a_high_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        (io_rd_in && io_addr_in == eac_pkg::OFF_ADDR_HIGH) |=> io_rdata_out[7:1] == 7'h00)
        else $error("high address upper bits nonzero");
    a_ctl_top_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        (io_rd_in && io_addr_in == eac_pkg::OFF_CONTROL) |=> io_rdata_out[7:6] == 2'h0)
        else $error("control top bits nonzero");

    c_prog_start: cover property (@(posedge clk_in) disable iff (srst_in) start_ok);
    c_prog_done: cover property (@(posedge clk_in) disable iff (srst_in) prog_done);
    c_read: cover property (@(posedge clk_in) disable iff (srst_in) read_ok);
    c_arm_lapse: cover property (@(posedge clk_in) disable iff (srst_in)
        $fell(master_prog_arm_q) && !prog_en_q);
endmodule // eac_controller

// File: eac_controller_test.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
module eac_controller_test;
    localparam int   EW_CYCLES = 40;
    localparam int   SG_CYCLES = 20;
    localparam logic [5:0] CTL = eac_pkg::OFF_CONTROL;
    localparam logic [5:0] DAT = eac_pkg::OFF_DATA_BYTE;
    localparam logic [5:0] LOW = eac_pkg::OFF_ADDR_LOW;
    localparam logic [5:0] HIGH = eac_pkg::OFF_ADDR_HIGH;

    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        glob_ie = 1'b0;
    logic [5:0]  io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        stall;
    logic        irq;
    logic        busy;
    logic [31:0] busy_cnt = 32'h0;
    logic [31:0] n;
    logic [7:0]  v;
    logic [1:0]  modes [3] = '{2'h0, 2'h2, 2'h1};
    logic [7:0]  wdat [3] = '{8'h3C, 8'h0F, 8'h00};
    logic [7:0]  expb [3] = '{8'h3C, 8'h0C, 8'hFF};
    int          miscompares = 0;
    int          check_count = 0;

    always #10 clk_in = ~clk_in;
    // Counts cycles of programming in progress
    always @(negedge clk_in) if (busy === 1'b1) busy_cnt <= busy_cnt + 32'h1;

    eac_controller #(.ERASE_WRITE_CYCLES(EW_CYCLES), .SINGLE_CYCLES(SG_CYCLES))
    eac_controller_i (
        .clk_in               (clk_in),
        .srst_in              (srst_in),
        .io_addr_in           (io_addr),
        .io_wr_in             (io_wr),
        .io_rd_in             (io_rd),
        .io_wdata_in          (io_wdata),
        .global_irq_enable_in (glob_ie),
        .io_rdata_out         (io_rdata),
        .cpu_stall_out        (stall),
        .nv_ready_irq_out     (irq),
        .nv_busy_out          (busy)
    );

    eac_core_model eac_core_model_i (
        .clk_in       (clk_in),
        .stall_in     (stall),
        .rdata_in     (io_rdata),
        .io_addr_out  (io_addr),
        .io_wr_out    (io_wr),
        .io_rd_out    (io_rd),
        .io_wdata_out (io_wdata)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        eac_core_model_i.io_write(a, d);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        eac_core_model_i.io_read(a, d);
    endtask

    // Stall may rise a cycle late, so allow a short lead-in
    task automatic count_stall(output logic [31:0] c);
        int w;
        c = 32'h0;
        w = 0;
        while (stall !== 1'b1 && w < 3) begin @(negedge clk_in); w++; end
        while (stall === 1'b1 && c < 16) begin @(negedge clk_in); c++; end
    endtask

    task automatic prog(input logic [1:0] m, input logic [7:0] d);
        busy_cnt = 32'h0;
        wr(HIGH, 8'h01);
        wr(LOW, 8'hA5);
        wr(DAT, d);
        wr(CTL, {2'h0, m, 4'hC});
        wr(CTL, {2'h0, m, 4'hA});
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (20) @(negedge clk_in);
        srst_in = 1'b0;
        rd(CTL, v); check(v, 8'h00);
        rd(DAT, v); check(v, eac_pkg::DATA_RESET);
        rd(6'h10, v); check(v, 8'h00);
        wr(HIGH, 8'hFF); rd(HIGH, v); check(v, 8'h01);
        wr(LOW, 8'hA5); rd(LOW, v); check(v, 8'hA5);
        wr(CTL, 8'h02); check(busy, 1'b0);
        wr(CTL, 8'h04); rd(CTL, v); check(v, 8'h04);
        repeat (4) @(negedge clk_in);
        rd(CTL, v); check(v, 8'h00);
        wr(CTL, 8'h02); check(busy, 1'b0);
        wr(CTL, 8'h34); wr(CTL, 8'h32); check(busy, 1'b0);
        glob_ie = 1'b1;
        for (int i = 0; i < 3; i++) begin
            prog(modes[i], wdat[i]);
            count_stall(n); check(n, 32'h2);
            check(busy, 1'b1);
            check(irq, 1'b0);
            if (i == 0) begin
                wr(CTL, 8'h2A); rd(CTL, v); check(v, 8'h0A);
                wr(LOW, 8'h00); rd(LOW, v); check(v, 8'hA5);
                wr(CTL, 8'h0B); count_stall(n); check(n, 32'h0);
            end
            eac_core_model_i.read_byte(v); check(v, expb[i]);
            check(busy_cnt, (i == 0) ? EW_CYCLES : SG_CYCLES);
            check(irq, 1'b1);
        end
        wr(CTL, 8'h09); count_stall(n); check(n, 32'h4);
        rd(DAT, v); check(v, 8'hFF);
        glob_ie = 1'b0;
        @(negedge clk_in); check(irq, 1'b0);
        glob_ie = 1'b1;
        wr(CTL, 8'h00); check(irq, 1'b0);
        prog(2'h2, 8'h5A);
        repeat (5) @(negedge clk_in);
        srst_in = 1'b1;
        @(negedge clk_in);
        srst_in = 1'b0;
        check(busy, 1'b1);
        rd(CTL, v); check(v, 8'h22);
        eac_core_model_i.read_byte(v); check(v, 8'h5A);
        srst_in = 1'b1;
        @(negedge clk_in);
        srst_in = 1'b0;
        rd(CTL, v); check(v, 8'h00);
        final_report();
    end
endmodule // eac_controller_test

// File: eac_core_model.sv
// Behavioural processor core issuing I/O register reads and writes
`timescale 1ns/1ps
module eac_core_model (
    input  wire logic       clk_in,
    input  wire logic       stall_in,
    input  wire logic [7:0] rdata_in,
    output logic [5:0]      io_addr_out,
    output logic            io_wr_out,
    output logic            io_rd_out,
    output logic [7:0]      io_wdata_out
);
    initial begin
        io_addr_out  = 6'h00;
        io_wr_out    = 1'b0;
        io_rd_out    = 1'b0;
        io_wdata_out = 8'h00;
    end

    // A halted core issues nothing
    task automatic hold_for_stall();
        int n;
        n = 0;
        while (stall_in === 1'b1 && n < 16) begin
            @(negedge clk_in);
            n++;
        end
    endtask

    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        hold_for_stall();
        io_addr_out  = a;
        io_wdata_out = (a == eac_pkg::OFF_CONTROL) ? (d & 8'h7F) : d;
        io_wr_out    = 1'b1;
        @(negedge clk_in);
        io_wr_out    = 1'b0;
        // Released bus shows junk, not the last value
        io_addr_out  = ~a;
        io_wdata_out = ~d;
    endtask

    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_in);
        hold_for_stall();
        io_addr_out = a;
        io_rd_out   = 1'b1;
        @(negedge clk_in);
        io_rd_out   = 1'b0;
        io_addr_out = ~a;
        @(negedge clk_in);
        d = rdata_in;
    endtask

    // Caller loads the address first
    task automatic read_byte(output logic [7:0] d);
        int n;
        n = 0;
        io_read(eac_pkg::OFF_CONTROL, d);
        while (d[eac_pkg::CTL_PROG_EN] !== 1'b0 && n < 64) begin
            io_read(eac_pkg::OFF_CONTROL, d);
            n++;
        end
        io_write(eac_pkg::OFF_CONTROL, 8'h09);
        io_read(eac_pkg::OFF_DATA_BYTE, d);
    endtask
endmodule // eac_core_model

// File: eac_nv_array.sv
// Byte-wide nonvolatile storage array with registered read data
`timescale 1ns/1ps
module eac_nv_array #(
    parameter int DEPTH  = 512,
    parameter int ADDR_W = 9
) (
    input  wire logic clk_in,
    eac_nv_if.mem     nv
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rd_q;

    // Write only can clear bits but never set them
    function automatic logic [7:0] program_byte(input logic [1:0] mode,
                                                input logic [7:0] old_v,
                                                input logic [7:0] new_v);
        case (mode)
            eac_pkg::MODE_ERASE_WRITE: program_byte = new_v;
            eac_pkg::MODE_ERASE_ONLY:  program_byte = eac_pkg::ERASED_BYTE;
            eac_pkg::MODE_WRITE_ONLY:  program_byte = old_v & new_v;
            default:                   program_byte = old_v;
        endcase
    endfunction

    always_ff @(posedge clk_in) begin
        if (nv.wr_en) begin
            mem_q[nv.wr_addr] <= program_byte(nv.wr_mode, mem_q[nv.wr_addr], nv.wr_data);
        end
        if (nv.rd_en) begin
            rd_q <= mem_q[nv.rd_addr];
        end
    end

    assign nv.rd_data = rd_q;
endmodule // eac_nv_array

// File: eac_nv_if.sv
// Signals between the access controller and its storage array
`timescale 1ns/1ps
interface eac_nv_if #(parameter int ADDR_W = 9);
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]        rd_data;
    logic              wr_en;
    logic [1:0]        wr_mode;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;

    modport ctrl (output rd_en, output rd_addr, input rd_data,
                  output wr_en, output wr_mode, output wr_addr, output wr_data);
    modport mem  (input rd_en, input rd_addr, output rd_data,
                  input wr_en, input wr_mode, input wr_addr, input wr_data);
endinterface

// File: eac_pkg.sv
// Constants shared by the nonvolatile access controller and its storage array
package eac_pkg;

    // I/O register offsets
    localparam logic [5:0] OFF_CONTROL   = 6'h1C;
    localparam logic [5:0] OFF_DATA_BYTE = 6'h1D;
    localparam logic [5:0] OFF_ADDR_LOW  = 6'h1E;
    localparam logic [5:0] OFF_ADDR_HIGH = 6'h1F;

    // Control register field positions
    localparam int CTL_READ_STROBE = 0;
    localparam int CTL_PROG_EN     = 1;
    localparam int CTL_MASTER_ARM  = 2;
    localparam int CTL_READY_IRQ   = 3;
    localparam int CTL_MODE_LO     = 4;
    localparam int CTL_MODE_HI     = 5;

    // Programming mode encodings
    localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
    localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
    localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
    localparam logic [1:0] MODE_RESERVED    = 2'h3;

    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS        = 20;
    localparam int T_ERASE_WRITE_NS     = 3400000;
    localparam int T_SINGLE_NS          = 1800000;
    localparam int ERASE_WRITE_CYCLES   = T_ERASE_WRITE_NS / CLK_PERIOD_NS;
    localparam int SINGLE_CYCLES        = T_SINGLE_NS / CLK_PERIOD_NS;
    localparam int PROG_CNT_W           = 18;
    localparam logic [2:0] ARM_CYCLES   = 3'h4;
    localparam logic [2:0] PROG_STALL   = 3'h2;
    localparam logic [2:0] READ_STALL   = 3'h4;

    // Erased byte value
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

endpackage
